// ---- core/amb_top.sv ----
// Adapter end of the processor micro-bus: select, decode, data buffer, service request.
// Assumes host strobes rd or wr for one cycle per transfer, synchronous to clk.
`timescale 1ns/1ps
module amb_top #(
   parameter logic [amb_pkg::SW-1:0] ADAPTER_ADDR = 4'h0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [amb_pkg::SW-1:0] sel_i,
   input wire logic [amb_pkg::AW-1:0] reg_addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [amb_pkg::DW-1:0] data_in,
   output logic [amb_pkg::DW-1:0] data_out,
   output logic data_oe,
   output logic srq,
   output logic op_go,
   output logic [amb_pkg::BW-1:0] op_cmd,
   output logic pout_valid,
   input wire logic pout_ready,
   output logic [amb_pkg::BW-1:0] pout_data,
   input wire logic pin_valid,
   output logic pin_ready,
   input wire logic [amb_pkg::BW-1:0] pin_data,
   input wire logic per_eor,
   input wire logic per_chg
);
   amb_buf_if bif ();
   amb_buf u_buf (
      .clk(clk),
      .rstn(rstn),
      .bi(bif.store)
   );

   amb_pkg::amb_op_t op_q, op_d;
   logic [amb_pkg::BW-1:0] cmd_q;
   logic [amb_pkg::BW-1:0] in_q;
   logic in_full_q;
   logic srq_q, hold_q, eor_q, err_q, ovr_q, go_q;

   // Decode
   wire sel_hit = (sel_i == ADAPTER_ADDR);
   wire in_range = (reg_addr <= amb_pkg::A_LAST);
   wire rd_acc = sel_hit & rd & in_range;
   wire wr_acc = sel_hit & wr & in_range;
   wire wr_data = wr_acc & (reg_addr == amb_pkg::A_DATA);
   wire wr_cmd = wr_acc & (reg_addr == amb_pkg::A_CMD);
   wire wr_mclr = wr_acc & (reg_addr == amb_pkg::A_CLR);
   wire wr_drop = wr_acc & (reg_addr == amb_pkg::A_DROP);
   wire wr_init = wr_acc & (reg_addr == amb_pkg::A_INIT);
   wire wr_eob = wr_acc & (reg_addr == amb_pkg::A_EOB);
   wire rd_data = rd_acc & (reg_addr == amb_pkg::A_DATA);
   wire rd_sclr = rd_acc & (reg_addr == amb_pkg::A_CLR);
   wire [amb_pkg::BW-1:0] wbyte = data_in[amb_pkg::BW-1:0];

   wire dir_out = cmd_q[amb_pkg::CMD_OUT_BIT];
   wire run = (op_q == amb_pkg::OP_RUN);
   wire pin_take = pin_valid & pin_ready;
   wire need_data = run & (dir_out ? bif.in_ready : in_full_q);
   wire err_set = wr_eob & ~(eor_q | per_eor);
   wire ovr_set = wr_data & ~bif.in_ready;
   wire stat_evt = per_chg | per_eor | err_set | ovr_set;
   wire served = wr_data | rd_data | wr_drop;
   wire start = wr_cmd | wr_init;

   // Peripheral side stands still while waiting for the host
   assign pin_ready = ~in_full_q & ~hold_q & run & ~dir_out;
   assign pout_valid = bif.out_valid & ~hold_q;
   assign pout_data = bif.out_data;
   assign bif.out_ready = pout_ready & ~hold_q;
   assign bif.in_valid = wr_data;
   assign bif.in_data = wbyte;
   assign bif.flush = wr_mclr;

   assign srq = srq_q;
   assign op_go = go_q;
   assign op_cmd = cmd_q;

   // Read mux of registered state; drivers only while selected and reading
   wire [amb_pkg::DW-1:0] stat_w = {amb_pkg::BYTE_ZERO, ovr_q, err_q, eor_q, ~bif.in_ready,
      in_full_q, run, hold_q, srq_q};
   wire [amb_pkg::DW-1:0] rmux =
      (reg_addr == amb_pkg::A_DATA) ? {amb_pkg::BYTE_ZERO, in_q} :
      (reg_addr == amb_pkg::A_CMD) ? {amb_pkg::BYTE_ZERO, cmd_q} :
      (reg_addr == amb_pkg::A_STAT) ? stat_w : amb_pkg::WORD_ZERO;
   assign data_oe = sel_hit & rd;
   assign data_out = data_oe ? rmux : amb_pkg::WORD_ZERO;

   always_comb begin
      op_d = op_q;
      case (op_q)
         amb_pkg::OP_IDLE: begin
            if (start) begin
               op_d = amb_pkg::OP_RUN;
            end
         end
         amb_pkg::OP_RUN: begin
            if (wr_eob) begin
               op_d = amb_pkg::OP_IDLE;
            end
         end
         default: begin
            op_d = amb_pkg::OP_IDLE;
         end
      endcase
      if (wr_mclr) begin
         op_d = amb_pkg::OP_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_q <= amb_pkg::OP_IDLE;
         cmd_q <= amb_pkg::CMD_RST;
         go_q <= 1'b0;
      end else begin
         op_q <= op_d;
         go_q <= start & ~wr_mclr;
         if (wr_mclr) begin
            cmd_q <= amb_pkg::CMD_RST;
         end else if (wr_cmd) begin
            cmd_q <= wbyte;
         end
      end
   end

   // Inbound byte register; the host read empties it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_q <= amb_pkg::BYTE_ZERO;
         in_full_q <= 1'b0;
      end else begin
         if (pin_take) begin
            in_q <= pin_data;
         end
         in_full_q <= ~wr_mclr & (pin_take | (in_full_q & ~rd_data));
      end
   end

   // Event flags: a set in the same cycle as its clear wins, except need_data on srq_q, where served or wr_mclr wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         srq_q <= 1'b0;
         hold_q <= 1'b0;
         eor_q <= 1'b0;
         err_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         srq_q <= stat_evt | (need_data & ~served & ~wr_mclr) |
            (srq_q & ~served & ~wr_mclr);
         hold_q <= stat_evt | (hold_q & ~rd_acc & ~wr_acc);
         eor_q <= per_eor | (eor_q & ~start & ~wr_mclr);
         err_q <= err_set | (err_q & ~rd_sclr & ~wr_mclr);
         ovr_q <= ovr_set | (ovr_q & ~rd_sclr & ~wr_mclr);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_stat_raise;
      stat_evt;
   endsequence
   sequence s_waiting;
      srq_q && hold_q && !pin_ready && !pout_valid;
   endsequence
   // Inbound byte taken with no other event in the way
   sequence s_byte_in;
      pin_take && !stat_evt;
   endsequence

   foreign_ignored_a: assert property ((wr && !sel_hit && !per_eor) |=>
      $stable(cmd_q) && !go_q && $stable(eor_q))
      else $error("foreign select changed adapter state");
   status_hold_a: assert property (s_stat_raise |=> s_waiting)
      else $error("status change did not raise request and hold");
   cmd_start_a: assert property (wr_cmd && !wr_mclr |=>
      go_q && op_cmd == $past(wbyte) && run)
      else $error("command write did not start operation");
   mclr_drop_a: assert property ((wr_mclr && !stat_evt) |=>
      !srq_q && !run && !err_q && !pout_valid)
      else $error("master clear left state behind");
   drop_req_a: assert property ((wr_drop && !stat_evt) |=> !srq_q)
      else $error("drop command left request up");
   need_req_a: assert property ((need_data && !served && !wr_mclr) |=> srq)
      else $error("data need did not raise request");
   // Error may only go once a status clear or master clear was seen
   eob_err_a: assert property ((wr_eob && !eor_q && !per_eor && !wr_mclr) |=>
      err_q ##1 (err_q || $past(rd_sclr || wr_mclr)))
      else $error("missing end of record not flagged");
   range_ign_a: assert property ((sel_hit && wr && reg_addr > amb_pkg::A_LAST)
      |=> $stable(cmd_q) && !go_q) else $error("out of range address acted");
   read_back_a: assert property ((wr_cmd && !wr_mclr) ##1 !wr_acc ##1
      (sel_hit && rd && reg_addr == amb_pkg::A_CMD) |->
      data_out[amb_pkg::BW-1:0] == $past(wbyte, 2)) else $error("command readback wrong");
   bus_release_a: assert property ((!sel_hit || !rd) |-> !data_oe)
      else $error("bus driven while not read-selected");
   sclr_err_a: assert property ((rd_sclr && !err_set) |=> !err_q)
      else $error("status clear read left error set");
   one_byte_a: assert property ((wr_data && !stat_evt) |=> !srq)
      else $error("request kept up after a served byte");
   init_go_a: assert property (wr_init |=> go_q && run)
      else $error("initiate command did not start operation");
   in_req_a: assert property (s_byte_in ##1 (!rd_data && !wr_acc && !stat_evt) |=> srq)
      else $error("inbound byte did not raise request");
   range_read_a: assert property ((sel_hit && rd && !in_range) |->
      data_oe && data_out == amb_pkg::WORD_ZERO) else $error("out of range read not zero");
endmodule

// ---- core/amb_pkg.sv ----
// Shared constants and types of the adapter micro-bus port.
// Assumes one 100 MHz clock and a host that strobes read or write per cycle.
package amb_pkg;
   localparam int DW = 16;
   localparam int SW = 4;
   localparam int AW = 4;
   localparam int BW = 8;
   localparam int BUF_DEPTH = 2;
   localparam int CW = 2;

   // Register and command addresses inside the adapter's block
   localparam logic [AW-1:0] A_DATA = 4'h0;
   localparam logic [AW-1:0] A_CMD = 4'h1;
   localparam logic [AW-1:0] A_STAT = 4'h2;
   localparam logic [AW-1:0] A_CLR = 4'h3;
   localparam logic [AW-1:0] A_DROP = 4'h4;
   localparam logic [AW-1:0] A_INIT = 4'h5;
   localparam logic [AW-1:0] A_EOB = 4'h6;
   localparam logic [AW-1:0] A_LAST = 4'h7;

   // Status word bit positions
   localparam int SB_SRQ = 0;
   localparam int SB_HOLD = 1;
   localparam int SB_RUN = 2;
   localparam int SB_INF = 3;
   localparam int SB_OUTF = 4;
   localparam int SB_EOR = 5;
   localparam int SB_ERR = 6;
   localparam int SB_OVR = 7;

   // Command byte: bit set means output sequence toward the peripheral
   localparam int CMD_OUT_BIT = 0;

   localparam logic [BW-1:0] CMD_RST = 8'h00;
   localparam logic [BW-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DW-1:0] WORD_ZERO = 16'h0000;
   localparam logic [CW-1:0] CNT_ZERO = 2'h0;
   localparam logic [CW-1:0] CNT_ONE = 2'h1;
   localparam logic [CW-1:0] CNT_FULL = 2'h2;

   typedef enum {OP_IDLE, OP_RUN} amb_op_t;
endpackage

// ---- core/amb_buf_if.sv ----
// Carrier between the adapter core and its two-entry output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface amb_buf_if;
   logic flush;
   logic in_valid;
   logic in_ready;
   logic [amb_pkg::BW-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [amb_pkg::BW-1:0] out_data;
   modport store (input flush, input in_valid, input in_data, input out_ready,
      output in_ready, output out_valid, output out_data);
   modport user (output flush, output in_valid, output in_data, output out_ready,
      input in_ready, input out_valid, input out_data);
endinterface

// ---- core/amb_buf.sv ----
// Two-entry byte buffer with valid and ready on both sides.
// Assumes the user side holds data stable while in_valid is high.
`timescale 1ns/1ps
module amb_buf (
   input wire logic clk,
   input wire logic rstn,
   amb_buf_if.store bi
);
   logic [amb_pkg::BW-1:0] mem_q [amb_pkg::BUF_DEPTH];
   logic wp_q;
   logic rp_q;
   logic [amb_pkg::CW-1:0] cnt_q;
   wire push = bi.in_valid & bi.in_ready;
   wire pop = bi.out_valid & bi.out_ready;

   assign bi.in_ready = (cnt_q != amb_pkg::CNT_FULL);
   assign bi.out_valid = (cnt_q != amb_pkg::CNT_ZERO);
   assign bi.out_data = mem_q[rp_q];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= amb_pkg::CNT_ZERO;
      end else if (bi.flush) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= amb_pkg::CNT_ZERO;
      end else begin
         wp_q <= wp_q ^ push;
         rp_q <= rp_q ^ pop;
         if (push && !pop) begin
            cnt_q <= cnt_q + amb_pkg::CNT_ONE;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - amb_pkg::CNT_ONE;
         end
      end
   end

   // Storage needs no reset; it is only read once counted valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= bi.in_data;
      end
   end
endmodule

// ---- test/amb_host.sv ----
// Host side model: drives select, address and strobes on the micro-bus.
// Assumes one transfer per call, strobes held one cycle.
`timescale 1ns/1ps
module amb_host (
   input wire logic clk,
   output logic [3:0] sel_i,
   output logic [3:0] reg_addr,
   output logic rd,
   output logic wr,
   output logic [15:0] bus_q,
   input wire logic [15:0] data_out,
   input wire logic data_oe
);
   initial begin
      sel_i = 4'hf;
      reg_addr = 4'hf;
      rd = 1'b0;
      wr = 1'b0;
      bus_q = 16'h0000;
   end
   // One strobe at a time, never both
   task automatic acc(input logic [3:0] s, input logic [3:0] a, input logic w,
      input logic [7:0] d, output logic [15:0] q, output logic oe);
      @(posedge clk);
      sel_i <= s;
      reg_addr <= a;
      rd <= !w;
      wr <= w;
      bus_q <= {8'h00, d};
      @(negedge clk);
      q = data_out;
      oe = data_oe;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      sel_i <= 4'hf;
      // Released bus shows inverted pattern, not the old byte
      bus_q <= ~bus_q;
      reg_addr <= ~a;
   endtask
endmodule

// ---- test/amb_top_tb.sv ----
// Self-checking bench of the adapter micro-bus port.
// Assumes amb_host as host and the bench as peripheral.
`timescale 1ns/1ps
module amb_top_tb;
   localparam logic [3:0] ME = 4'h9;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] sel_i, reg_addr;
   logic rd, wr, data_oe, srq, op_go, pout_valid, pin_ready;
   logic [15:0] bus_q, data_out, bus;
   logic [7:0] op_cmd, pout_data;
   logic pout_ready = 1'b0, pin_valid = 1'b0, per_eor = 1'b0, per_chg = 1'b0;
   logic [7:0] pin_data = 8'h00;
   logic [15:0] q;
   logic oe;
   int n_errors = 0;
   int tests_run = 0;
   always #5 clk = ~clk;
   // Host drives on write, adapter on read
   assign bus = data_oe ? data_out : (wr ? bus_q : 16'hzzzz);
   amb_host i_host (.clk(clk), .sel_i(sel_i), .reg_addr(reg_addr), .rd(rd), .wr(wr),
      .bus_q(bus_q), .data_out(data_out), .data_oe(data_oe));
   amb_top #(.ADAPTER_ADDR(ME)) i_dut (.clk(clk), .rstn(rstn), .sel_i(sel_i),
      .reg_addr(reg_addr), .rd(rd), .wr(wr), .data_in(bus), .data_out(data_out),
      .data_oe(data_oe), .srq(srq), .op_go(op_go), .op_cmd(op_cmd),
      .pout_valid(pout_valid), .pout_ready(pout_ready), .pout_data(pout_data),
      .pin_valid(pin_valid), .pin_ready(pin_ready), .pin_data(pin_data),
      .per_eor(per_eor), .per_chg(per_chg));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_srq(input logic e);
      int i;
      for (i = 0; i < 8 && srq !== e; i++) @(negedge clk);
      chk("srq", {15'h0, e}, {15'h0, srq});
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      i_host.acc(ME, a, 1'b1, d, q, oe);
   endtask
   task automatic t_reset();
      chk("reset outs", 16'h0000, {srq, op_go, op_cmd, pout_valid, pin_ready});
      $display("test reset done");
   endtask
   task automatic t_select();
      i_host.acc(4'h1, amb_pkg::A_CMD, 1'b1, 8'h55, q, oe);
      @(negedge clk);
      chk("op_cmd other sel", 16'h0000, {8'h00, op_cmd});
      i_host.acc(4'h1, amb_pkg::A_CMD, 1'b0, 8'h00, q, oe);
      chk("oe other sel", 16'h0000, {15'h0, oe});
      i_host.acc(ME, 4'h7, 1'b0, 8'h00, q, oe);
      chk("empty addr read", 16'h0001, {q[14:0], oe});
      i_host.acc(ME, 4'ha, 1'b1, 8'h77, q, oe);
      @(negedge clk);
      chk("op_cmd high addr", 16'h0000, {8'h00, op_cmd});
      i_host.acc(ME, 4'hb, 1'b0, 8'h00, q, oe);
      chk("high addr read", 16'h0001, {q[14:0], oe});
      $display("test select done");
   endtask
   task automatic take_out(input logic [7:0] e);
      int i;
      for (i = 0; i < 8 && !(pout_valid && pout_ready); i++) @(negedge clk);
      chk("pout_data", {8'h00, e}, {8'h00, pout_data});
      @(negedge clk);
   endtask
   task automatic t_out();
      wr_reg(amb_pkg::A_CMD, 8'h81);
      @(negedge clk);
      chk("op_go op_cmd", 16'h0181, {7'h0, op_go, op_cmd});
      wait_srq(1'b1);
      wr_reg(amb_pkg::A_DATA, 8'h11);
      @(negedge clk);
      chk("srq served", 16'h0000, {15'h0, srq});
      wait_srq(1'b1);
      wr_reg(amb_pkg::A_DATA, 8'h22);
      wr_reg(amb_pkg::A_DATA, 8'h33);
      i_host.acc(ME, amb_pkg::A_STAT, 1'b0, 8'h00, q, oe);
      chk("ovr full", 16'h0090, q & 16'h0090);
      @(posedge clk);
      pout_ready <= 1'b1;
      take_out(8'h11);
      take_out(8'h22);
      chk("third byte dropped", 16'h0000, {15'h0, pout_valid});
      @(posedge clk);
      pout_ready <= 1'b0;
      $display("test output done");
   endtask
   task automatic t_in();
      int i;
      wr_reg(amb_pkg::A_CLR, 8'h00);
      @(negedge clk);
      chk("master clear", 16'h0000, {7'h0, srq, op_cmd});
      wr_reg(amb_pkg::A_CMD, 8'h80);
      i_host.acc(ME, amb_pkg::A_CMD, 1'b0, 8'h00, q, oe);
      chk("cmd readback", 16'h0080, q);
      // Offer stands until the edge at which ready is seen high
      pin_data <= 8'hc4;
      pin_valid <= 1'b1;
      @(negedge clk);
      for (i = 0; i < 8 && !pin_ready; i++) @(negedge clk);
      @(posedge clk);
      pin_valid <= 1'b0;
      wait_srq(1'b1);
      i_host.acc(ME, amb_pkg::A_DATA, 1'b0, 8'h00, q, oe);
      chk("in byte", 16'h80c4, {oe, q[14:0]});
      repeat (2) @(negedge clk);
      chk("srq after read", 16'h0000, {15'h0, srq});
      $display("test input done");
   endtask
   task automatic t_events();
      wr_reg(amb_pkg::A_EOB, 8'h00);
      i_host.acc(ME, amb_pkg::A_STAT, 1'b0, 8'h00, q, oe);
      chk("err bit", 16'h0040, q & 16'h0040);
      i_host.acc(ME, amb_pkg::A_CLR, 1'b0, 8'h00, q, oe);
      i_host.acc(ME, amb_pkg::A_STAT, 1'b0, 8'h00, q, oe);
      chk("err cleared", 16'h0000, q & 16'h0040);
      wr_reg(amb_pkg::A_DROP, 8'h00);
      @(negedge clk);
      chk("drop", 16'h0000, {15'h0, srq});
      @(posedge clk);
      per_chg <= 1'b1;
      @(posedge clk);
      per_chg <= 1'b0;
      wait_srq(1'b1);
      wr_reg(amb_pkg::A_DROP, 8'h00);
      @(negedge clk);
      chk("drop again", 16'h0000, {15'h0, srq});
      wr_reg(amb_pkg::A_INIT, 8'h00);
      @(negedge clk);
      chk("initiate", 16'h0180, {7'h0, op_go, op_cmd});
      @(posedge clk);
      per_eor <= 1'b1;
      @(posedge clk);
      per_eor <= 1'b0;
      wr_reg(amb_pkg::A_EOB, 8'h00);
      i_host.acc(ME, amb_pkg::A_STAT, 1'b0, 8'h00, q, oe);
      chk("eor no err", 16'h0020, q & 16'h0060);
      $display("test events done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      t_reset();
      t_select();
      t_out();
      t_in();
      t_events();
      complete_run();
   end
   // Whole run needs under a hundred cycles
   initial begin
      #50000;
      n_errors++;
      complete_run();
   end
endmodule
